/* File: verilog/idtw_core.sv */
/*
  Inter-drive token writer: rotates the master role over a node range
  (administrator), sends the configured single-register writes when this
  node is master, and stores writes aimed at this node.
  Assumes a frame transmitter and receiver on the same clock that handle
  RTU framing, CRC and silent intervals.
*/
module idtw_core
  import idtw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC  // Cycles per timeout unit
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  // Configuration
  input  wire logic [7:0]          node_address_setting,
  input  wire logic [7:0]          comm_role_selection,
  input  wire logic [7:0]          first_master_node,
  input  wire logic [7:0]          last_master_node,
  input  wire logic [7:0]          exchange_start_method,
  input  wire logic [7:0]          reception_timeout,    // Units, zero = none
  input  wire logic [7:0]          comm_error_action,
  input  wire logic [2:0]          write_count,
  input  wire logic [NSETS*8-1:0]  dest_node_sets,       // Set k at [8k+:8]
  input  wire logic [NSETS*16-1:0] dest_register_sets,   // Zero-based
  input  wire logic [NSETS*16-1:0] source_register_sets, // Zero-based
  // Activation pin
  input  wire logic                exchange_activation_input,
  // Local holding register read
  output logic [15:0]              src_addr_ff,
  input  wire logic [15:0]         src_data,
  // Local holding register write
  output logic                     hr_wr_ff,
  output logic [15:0]              hr_wr_addr_ff,
  output logic [15:0]              hr_wr_data_ff,
  // Frame transmitter
  output logic                     tx_req_ff,
  output logic [7:0]               tx_node_ff,
  output logic [7:0]               tx_func_ff,
  output logic [15:0]              tx_reg_ff,
  output logic [15:0]              tx_data_ff,
  input  wire logic                tx_done,
  // Frame receiver
  input  wire logic                rx_valid,
  input  wire logic [7:0]          rx_node,
  input  wire logic [7:0]          rx_func,
  input  wire logic [15:0]         rx_reg,
  input  wire logic [15:0]         rx_data,
  // Status
  output logic                     is_admin_ff,
  output logic                     is_master_ff,
  output logic                     timeout_err_ff,
  output logic [7:0]               cur_master_ff
);

  idtw_state_t state_ff;       // Sequencer state
  logic [1:0]  act_sync_ff;    // Activation pin synchroniser
  logic [2:0]  idx_ff;         // Current write set
  logic        sent_ff;        // Frame of this state issued
  logic        is_admin;       // Configured as administrator
  logic        is_part;        // Configured as participant
  logic        range_ok;       // Rotation range legal
  logic        run_en;         // Rotation may proceed
  logic [2:0]  wcnt;           // Effective write count
  logic [7:0]  set_node;       // Node of current set
  logic        set_ok;         // Current set destination legal
  logic [7:0]  nxt_master;     // Following node in rotation
  logic        tok_me;         // Token broadcast naming this node
  logic        done_rx;        // Current master reports end of turn
  logic        tmo;            // Wait expired

  assign is_admin = node_address_setting == ADMIN_NODE
                    && comm_role_selection == ROLE_ADMIN;
  assign is_part  = comm_role_selection == ROLE_PART;
  assign range_ok = first_master_node >= MASTER_MIN
                    && last_master_node <= MASTER_MAX
                    && first_master_node <= last_master_node;
  assign run_en   = is_admin && range_ok
                    && (exchange_start_method == START_ALWAYS
                        || (exchange_start_method == START_INPUT
                            && act_sync_ff[1]));
  assign wcnt     = (write_count > WCNT_MAX) ? 3'h0 : write_count;
  assign set_node = dest_node_sets[idx_ff*8 +: 8];
  assign set_ok   = set_node != BCAST_NODE && set_node <= DEST_MAX;
  assign nxt_master = (cur_master_ff >= last_master_node)
                      ? first_master_node
                      : cur_master_ff + 8'h1;
  // Token and end-of-turn frames, carried as ordinary writes
  assign tok_me   = rx_valid && rx_node == BCAST_NODE && rx_func == FC_WRITE_ONE
                    && rx_reg == TOKEN_REG && rx_data[7:0] == node_address_setting;
  assign done_rx  = rx_valid && rx_node == ADMIN_NODE && rx_func == FC_WRITE_ONE
                    && rx_reg == TOKEN_REG && rx_data[7:0] == cur_master_ff;

  // Reception wait timer
  idtw_timeout #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tmo (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (state_ff == IDTW_WAIT),
    .limit   (reception_timeout),
    .expired (tmo)
  );

  // Activation pin, two flops before use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      act_sync_ff <= 2'h0;
    end else begin
      act_sync_ff <= {act_sync_ff[0], exchange_activation_input};
    end
  end

  // Role flags for status
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      is_admin_ff <= 1'b0;
    end else begin
      is_admin_ff <= is_admin;
    end
  end

  // Store writes addressed to this node, master or not
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hr_wr_ff      <= 1'b0;
      hr_wr_addr_ff <= 16'h0;
      hr_wr_data_ff <= 16'h0;
    end else begin
      hr_wr_ff <= 1'b0;
      if (rx_valid && rx_node == node_address_setting
          && rx_func == FC_WRITE_ONE && rx_reg != TOKEN_REG) begin
        hr_wr_ff      <= 1'b1;
        hr_wr_addr_ff <= rx_reg;
        hr_wr_data_ff <= rx_data;
      end
    end
  end

  // Sequencer: grant, wait, send, report
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff       <= IDTW_IDLE;
      idx_ff         <= 3'h0;
      sent_ff        <= 1'b0;
      is_master_ff   <= 1'b0;
      timeout_err_ff <= 1'b0;
      cur_master_ff  <= MASTER_MIN;
      src_addr_ff    <= 16'h0;
      tx_req_ff      <= 1'b0;
      tx_node_ff     <= 8'h0;
      tx_func_ff     <= 8'h0;
      tx_reg_ff      <= 16'h0;
      tx_data_ff     <= 16'h0;
    end else begin
      tx_req_ff <= 1'b0;
      case (state_ff)
        // Waiting: admin starts rotation, participants wait for a grant
        IDTW_IDLE: begin
          is_master_ff <= 1'b0;
          sent_ff      <= 1'b0;
          if (run_en) begin
            cur_master_ff <= first_master_node;
            state_ff      <= IDTW_GRANT;
          end else if (!is_admin && is_part && tok_me) begin
            is_master_ff <= 1'b1;
            idx_ff       <= 3'h0;
            state_ff     <= IDTW_SEND;
          end
        end
        // Admin hands the role to the current node
        IDTW_GRANT: begin
          if (!run_en) begin
            state_ff <= IDTW_IDLE;
          end else if (cur_master_ff == node_address_setting) begin
            is_master_ff <= 1'b1;
            idx_ff       <= 3'h0;
            state_ff     <= IDTW_SEND;
          end else if (!sent_ff) begin
            tx_req_ff  <= 1'b1;
            tx_node_ff <= BCAST_NODE;
            tx_func_ff <= FC_WRITE_ONE;
            tx_reg_ff  <= TOKEN_REG;
            tx_data_ff <= {8'h0, cur_master_ff};
            sent_ff    <= 1'b1;
          end else if (tx_done) begin
            sent_ff  <= 1'b0;
            state_ff <= IDTW_WAIT;
          end
        end
        // Admin waits for the end-of-turn report
        IDTW_WAIT: begin
          if (done_rx) begin
            cur_master_ff <= nxt_master;
            state_ff      <= IDTW_GRANT;
          end else if (tmo) begin
            timeout_err_ff <= 1'b1;
            if (comm_error_action == ERR_IGNORE) begin
              cur_master_ff <= nxt_master;
              state_ff      <= IDTW_GRANT;
            end else begin
              state_ff <= IDTW_HALT;
            end
          end
        end
        // Pick the next write set, or finish the turn
        IDTW_SEND: begin
          sent_ff <= 1'b0;
          if (idx_ff >= wcnt) begin
            state_ff <= IDTW_DONE;
          end else if (!set_ok) begin
            idx_ff <= idx_ff + 3'h1;
          end else begin
            src_addr_ff <= source_register_sets[idx_ff*16 +: 16];
            state_ff    <= IDTW_XMIT;
          end
        end
        // Send one set with the local value just read
        IDTW_XMIT: begin
          if (!sent_ff) begin
            tx_req_ff  <= 1'b1;
            tx_node_ff <= set_node;
            tx_func_ff <= FC_WRITE_ONE;
            tx_reg_ff  <= dest_register_sets[idx_ff*16 +: 16];
            tx_data_ff <= src_data;
            sent_ff    <= 1'b1;
          end else if (tx_done) begin
            idx_ff   <= idx_ff + 3'h1;
            state_ff <= IDTW_SEND;
          end
        end
        // End of turn: admin advances, others report back
        IDTW_DONE: begin
          if (is_admin) begin
            is_master_ff  <= 1'b0;
            cur_master_ff <= nxt_master;
            state_ff      <= IDTW_GRANT;
          end else if (!sent_ff) begin
            tx_req_ff  <= 1'b1;
            tx_node_ff <= ADMIN_NODE;
            tx_func_ff <= FC_WRITE_ONE;
            tx_reg_ff  <= TOKEN_REG;
            tx_data_ff <= {8'h0, node_address_setting};
            sent_ff    <= 1'b1;
          end else if (tx_done) begin
            sent_ff  <= 1'b0;
            state_ff <= IDTW_IDLE;
          end
        end
        // Stopped after timeout until reset
        IDTW_HALT: begin
          is_master_ff <= 1'b0;
        end
        default: begin
          state_ff <= IDTW_IDLE;
        end
      endcase
    end
  end

  // Checks
  sequence s_write_rx;
    rx_valid && rx_node == node_address_setting && rx_func == FC_WRITE_ONE
      && rx_reg != TOKEN_REG;
  endsequence
  property p_store;
    @(posedge clk_sys) disable iff (!arst_n)
      s_write_rx |=> hr_wr_ff && hr_wr_addr_ff == $past(rx_reg);
  endproperty
  a_store: assert property (p_store) else $error("write not stored");
  property p_wcount;
    @(posedge clk_sys) disable iff (!arst_n) idx_ff <= WCNT_MAX;
  endproperty
  a_wcount: assert property (p_wcount) else $error("set index past five");
  property p_range;
    @(posedge clk_sys) disable iff (!arst_n)
      state_ff == IDTW_WAIT |-> cur_master_ff >= MASTER_MIN
                                && cur_master_ff <= MASTER_MAX;
  endproperty
  a_range: assert property (p_range) else $error("master out of range");
  property p_advance;
    @(posedge clk_sys) disable iff (!arst_n)
      state_ff == IDTW_WAIT && done_rx |=> cur_master_ff == $past(nxt_master)
                                          && state_ff == IDTW_GRANT;
  endproperty
  a_advance: assert property (p_advance) else $error("no advance");
  property p_wrap;
    @(posedge clk_sys) disable iff (!arst_n)
      state_ff == IDTW_WAIT && done_rx && cur_master_ff == last_master_node
        |=> cur_master_ff == first_master_node;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_admin_only;
    @(posedge clk_sys) disable iff (!arst_n)
      state_ff == IDTW_GRANT |-> is_admin;
  endproperty
  a_admin_only: assert property (p_admin_only) else $error("grant by non-admin");
  property p_func;
    @(posedge clk_sys) disable iff (!arst_n) tx_req_ff |-> tx_func_ff == FC_WRITE_ONE;
  endproperty
  a_func: assert property (p_func) else $error("bad function code");
  property p_timeout;
    @(posedge clk_sys) disable iff (!arst_n)
      state_ff == IDTW_WAIT && tmo && !done_rx && comm_error_action != ERR_IGNORE
        |=> state_ff == IDTW_HALT ##1 state_ff == IDTW_HALT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not halted");
  property p_stop;
    @(posedge clk_sys) disable iff (!arst_n)
      state_ff == IDTW_GRANT && !run_en |=> state_ff == IDTW_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("ran while disabled");

endmodule : idtw_core

/* File: verilog/idtw_pkg.sv */
/*
  Shared constants for the inter-drive token writer: role and start codes,
  frame function codes, the token register, limits and timing.
  Assumes a single 10 MHz system clock.
*/
package idtw_pkg;

  // Clock rate and time base
  localparam int unsigned CLK_HZ        = 10_000_000;  // System clock rate
  localparam int unsigned TICK_US       = 1000;        // Timeout unit, us
  localparam int unsigned TICK_CYC      = (CLK_HZ / 1_000_000) * TICK_US;

  // Role selection codes
  localparam logic [7:0] ROLE_ADMIN     = 8'h02;       // Administrator
  localparam logic [7:0] ROLE_PART      = 8'h01;       // Participating master

  // Start method codes
  localparam logic [7:0] START_INPUT    = 8'h00;       // Run while input is on
  localparam logic [7:0] START_ALWAYS   = 8'h01;       // Run continuously

  // Error action code that keeps the rotation going
  localparam logic [7:0] ERR_IGNORE     = 8'h02;

  // Node address limits
  localparam logic [7:0] ADMIN_NODE     = 8'h01;       // Administrator address
  localparam logic [7:0] BCAST_NODE     = 8'h00;       // Broadcast address
  localparam logic [7:0] MASTER_MIN     = 8'h01;       // Rotation range low
  localparam logic [7:0] MASTER_MAX     = 8'h08;       // Rotation range high
  localparam logic [7:0] DEST_MAX       = 8'hf7;       // Highest slave address

  // Write sets
  localparam int unsigned NSETS         = 5;           // Sets per master
  localparam logic [2:0]  WCNT_MAX      = 3'h5;        // Highest write count

  // Frame contents
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;       // Write single register
  localparam logic [15:0] TOKEN_REG     = 16'hfff0;    // Token hand-over register

  // Sequencer states, Gray along idle-grant-wait-send-xmit-done-halt
  typedef enum logic [2:0] {
    IDTW_IDLE  = 3'b000,
    IDTW_GRANT = 3'b001,
    IDTW_WAIT  = 3'b011,
    IDTW_SEND  = 3'b010,
    IDTW_XMIT  = 3'b110,
    IDTW_DONE  = 3'b111,
    IDTW_HALT  = 3'b101
  } idtw_state_t;

endpackage : idtw_pkg

/* File: verilog/idtw_timeout.sv */
/*
  Reception timeout timer: a prescaler makes a one-cycle tick per time
  unit, a counter of ticks fires a one-cycle expiry pulse.
  Assumes run is held for the whole wait and dropped to restart.
*/
module idtw_timeout
  import idtw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC  // Cycles per time unit
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Control
  input  wire logic       run,       // Count while high
  input  wire logic [7:0] limit,     // Units before expiry, zero = never
  // Result
  output logic            expired    // One-cycle pulse
);

  logic [31:0] pre_ff;   // Prescaler
  logic [7:0]  cnt_ff;   // Elapsed units
  logic        tick;     // One unit elapsed

  assign tick = run && (pre_ff == TICK_CYCLES - 1);

  // Prescaler, restarted whenever the wait stops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= 32'h0;
    end else if (!run || tick) begin
      pre_ff <= 32'h0;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end

  // Unit counter and expiry pulse
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff  <= 8'h0;
      expired <= 1'b0;
    end else if (!run) begin
      cnt_ff  <= 8'h0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (tick && limit != 8'h0) begin
        if (cnt_ff + 8'h1 >= limit) begin
          cnt_ff  <= 8'h0;
          expired <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 8'h1;
        end
      end
    end
  end

endmodule : idtw_timeout

/* File: tb/idtw_bus_model.sv */
/*
  Far side of the token writer: the other drives on the line and the
  local holding register file. Ends frames and remote master turns.
  Assumes the bench injects its own frames on the inj_ ports.
*/
module idtw_bus_model
  import idtw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Bench controls
  input  wire logic        slow,       // Long frame time
  input  wire logic        mute,       // Remote masters never answer
  input  wire logic        inj_valid,
  input  wire logic [7:0]  inj_node,
  input  wire logic [7:0]  inj_func,
  input  wire logic [15:0] inj_reg,
  input  wire logic [15:0] inj_data,
  // Local register file
  input  wire logic [15:0] src_addr,
  output logic      [15:0] src_data,
  // Line side of the design
  input  wire logic        tx_req,
  input  wire logic [7:0]  tx_node,
  input  wire logic [15:0] tx_reg,
  input  wire logic [15:0] tx_data,
  output logic             tx_done,
  output logic             rx_valid,
  output logic      [7:0]  rx_node,
  output logic      [7:0]  rx_func,
  output logic      [15:0] rx_reg,
  output logic      [15:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        busy_ff;  // Frame on the line
  logic [3:0]  dly_ff;   // Cycles left of the frame
  logic        tok_ff;   // Frame granted a remote master
  logic [7:0]  who_ff;   // Granted node
  logic [3:0]  gap_ff;   // Turn time of the remote master
  logic        end_ff;   // End-of-turn frame this cycle
  logic [15:0] idle_ff;  // Changing pattern on an idle line

  // Registers read back a fixed pattern of their address
  assign src_data = src_addr ^ 16'h3c3c;

  // Frame time, then a one-cycle completion
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      dly_ff  <= 4'h0;
      tok_ff  <= 1'b0;
      who_ff  <= 8'h00;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_req) begin
        busy_ff <= 1'b1;
        dly_ff  <= slow ? 4'h9 : 4'h1;
        who_ff  <= tx_data[7:0];
        tok_ff  <= (tx_node == BCAST_NODE) && (tx_reg == TOKEN_REG)
                   && (tx_data[7:0] != ADMIN_NODE) && !mute;
      end else if (busy_ff && dly_ff == 4'h0) begin
        tx_done <= 1'b1;
        busy_ff <= 1'b0;
      end else if (busy_ff) begin
        dly_ff <= dly_ff - 4'h1;
      end
    end
  end

  // Remote master takes its turn, then hands back to node one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap_ff  <= 4'h0;
      end_ff  <= 1'b0;
      idle_ff <= 16'h0000;
    end else begin
      idle_ff <= idle_ff + 16'h1357;
      end_ff  <= (gap_ff == 4'h1);
      if (tx_done && tok_ff) begin
        gap_ff <= 4'h6;
      end else if (gap_ff != 4'h0) begin
        gap_ff <= gap_ff - 4'h1;
      end
    end
  end

  // Bench frames win; idle fields never repeat the last frame
  assign rx_valid = inj_valid | end_ff;
  assign rx_node  = inj_valid ? inj_node : (end_ff ? ADMIN_NODE : ~idle_ff[7:0]);
  assign rx_func  = inj_valid ? inj_func : (end_ff ? FC_WRITE_ONE : idle_ff[15:8]);
  assign rx_reg   = inj_valid ? inj_reg : (end_ff ? TOKEN_REG : ~idle_ff);
  assign rx_data  = inj_valid ? inj_data : (end_ff ? {8'h00, who_ff} : idle_ff);
endmodule : idtw_bus_model

/* File: tb/idtw_core_tb.sv */
/*
  Self-checking bench of idtw_core: stores, rotation, writes, timeouts.
  Assumes idtw_pkg and the bus model idtw_bus_model.
*/
module idtw_core_tb
  import idtw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TK = 4;  // Shortened timeout unit
  // Config rows: node, role, first, last, start, pin, count
  localparam logic [55:0] QUIET [7] = '{
    {8'h02, 8'h02, 8'h01, 8'h03, 8'h01, 8'h00, 8'h02},
    {8'h01, 8'h03, 8'h01, 8'h03, 8'h01, 8'h00, 8'h02},
    {8'h01, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 8'h02},
    {8'h01, 8'h02, 8'h01, 8'h09, 8'h01, 8'h00, 8'h02},
    {8'h01, 8'h02, 8'h03, 8'h02, 8'h01, 8'h00, 8'h02},
    {8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00, 8'h06},
    {8'h01, 8'h02, 8'h01, 8'h03, 8'h00, 8'h00, 8'h02}};
  // Frame rows: node, function, register, data, stored
  localparam logic [55:0] STORE [5] = '{
    {8'h05, 8'h06, 16'h0010, 16'h1234, 8'h01},
    {8'h05, 8'h06, 16'hffff, 16'habcd, 8'h01},
    {8'h06, 8'h06, 16'h0012, 16'h5555, 8'h00},
    {8'h05, 8'h03, 16'h0013, 16'h6666, 8'h00},
    {8'h05, 8'h06, 16'hfff0, 16'h7777, 8'h00}};
  // Design inputs
  logic                clk_sys = 1'b0;
  logic                arst_n  = 1'b0;
  logic [7:0]          node, role, first, last, smeth, tmo, erract;
  logic [2:0]          wcnt;
  logic                act, slow, mute;
  logic [NSETS*8-1:0]  dnode;
  logic [NSETS*16-1:0] dreg, sreg;
  // Design outputs and line
  logic [15:0]         src_addr, src_data, hr_addr, hr_data, tx_reg, tx_data;
  logic [15:0]         rx_reg, rx_data, inj_reg, inj_data;
  logic [7:0]          tx_node, tx_func, rx_node, rx_func, cur, inj_node, inj_func;
  logic                hr_wr, tx_req, tx_done, rx_valid, is_admin, is_master, tmo_err;
  logic                inj_v;
  int                  n_mismatch = 0;
  int                  compares   = 0;
  int                  cyc        = 0;

  idtw_core #(.TICK_CYCLES(TK)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .node_address_setting(node), .comm_role_selection(role), .first_master_node(first),
    .last_master_node(last), .exchange_start_method(smeth), .reception_timeout(tmo),
    .comm_error_action(erract), .write_count(wcnt), .dest_node_sets(dnode),
    .dest_register_sets(dreg), .source_register_sets(sreg), .exchange_activation_input(act),
    .src_addr_ff(src_addr), .src_data(src_data), .hr_wr_ff(hr_wr), .hr_wr_addr_ff(hr_addr),
    .hr_wr_data_ff(hr_data), .tx_req_ff(tx_req), .tx_node_ff(tx_node), .tx_func_ff(tx_func),
    .tx_reg_ff(tx_reg), .tx_data_ff(tx_data), .tx_done(tx_done), .rx_valid(rx_valid),
    .rx_node(rx_node), .rx_func(rx_func), .rx_reg(rx_reg), .rx_data(rx_data),
    .is_admin_ff(is_admin), .is_master_ff(is_master), .timeout_err_ff(tmo_err),
    .cur_master_ff(cur));
  idtw_bus_model u_bus (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow), .mute(mute),
    .inj_valid(inj_v), .inj_node(inj_node), .inj_func(inj_func), .inj_reg(inj_reg),
    .inj_data(inj_data), .src_addr(src_addr), .src_data(src_data), .tx_req(tx_req),
    .tx_node(tx_node), .tx_reg(tx_reg), .tx_data(tx_data), .tx_done(tx_done),
    .rx_valid(rx_valid), .rx_node(rx_node), .rx_func(rx_func), .rx_reg(rx_reg),
    .rx_data(rx_data));

  // 10 MHz clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // Counts, verdict, stop
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // One comparison
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Reset with a new configuration
  task automatic setup(input logic [55:0] c);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    {node, role, first, last, smeth} <= c[55:16];
    act  <= c[8];
    wcnt <= c[2:0];
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
  endtask : setup

  // Wait for the next frame request and check it
  task automatic exp_tx(input logic [7:0] nd, input logic [15:0] rg, input logic [15:0] dt);
    for (int i = 0; i < 400 && tx_req !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("tx_req", 16'h0001, 16'(tx_req));
    chk("tx_node", 16'(nd), 16'(tx_node));
    chk("tx_func", 16'(FC_WRITE_ONE), 16'(tx_func));
    chk("tx_reg", rg, tx_reg);
    chk("tx_data", dt, tx_data);
    @(posedge clk_sys);
    #1;
  endtask : exp_tx

  // Write of set k and grant frame
  task automatic wr(input int k);
    exp_tx(dnode[8*k+:8], dreg[16*k+:16], sreg[16*k+:16] ^ 16'h3c3c);
  endtask : wr
  task automatic token(input logic [7:0] n);
    exp_tx(BCAST_NODE, TOKEN_REG, {8'h00, n});
  endtask : token

  // No frame request for n cycles
  task automatic no_tx(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      #1;
      if (tx_req !== 1'b0) seen++;
    end
    chk("quiet tx_req", 16'h0000, 16'(seen));
  endtask : no_tx

  // One frame from the line
  task automatic inject(input logic [55:0] f);
    @(posedge clk_sys);
    {inj_node, inj_func, inj_reg, inj_data} <= f[55:8];
    inj_v <= 1'b1;
    @(posedge clk_sys);
    inj_v <= 1'b0;
    #1;
  endtask : inject

  initial begin
    {node, role, first, last, smeth, erract} = '0;
    tmo = 8'h32;
    erract = ERR_IGNORE;
    wcnt = 3'h0;
    {act, slow, mute, inj_v} = 4'h0;
    {inj_node, inj_func, inj_reg, inj_data} = '0;
    for (int k = 0; k < NSETS; k++) begin
      dnode[8*k+:8]  = 8'h10 + 8'(k);
      dreg[16*k+:16] = 16'h0100 + 16'(k);
      sreg[16*k+:16] = 16'h0200 + 16'(k);
    end
    // Reset values
    repeat (10) @(posedge clk_sys);
    #1;
    chk("cur_master", 16'h0001, 16'(cur));
    chk("flags", 16'h0000, 16'({tx_req, hr_wr, is_admin, is_master, tmo_err}));
    // Stores at a participant before it is granted
    setup({8'h05, 8'h01, 8'h01, 8'h03, 8'h01, 8'h00, 8'h02});
    for (int r = 0; r < 5; r++) begin
      inject(STORE[r]);
      chk("hr_wr", 16'(STORE[r][0]), 16'(hr_wr));
      if (STORE[r][0]) begin
        chk("hr_addr", STORE[r][39:24], hr_addr);
        chk("hr_data", STORE[r][23:8], hr_data);
      end
    end
    // Grant to another node, then to this one with a slow line
    inject({BCAST_NODE, FC_WRITE_ONE, TOKEN_REG, 16'h0004, 8'h00});
    no_tx(30);
    @(posedge clk_sys);
    slow <= 1'b1;
    inject({BCAST_NODE, FC_WRITE_ONE, TOKEN_REG, 16'h0005, 8'h00});
    wr(0);
    wr(1);
    exp_tx(ADMIN_NODE, TOKEN_REG, 16'h0005);
    @(posedge clk_sys);
    slow <= 1'b0;
    // Configurations that must stay silent
    for (int r = 0; r < 7; r++) begin
      setup(QUIET[r]);
      no_tx(40);
    end
    @(posedge clk_sys);
    act <= 1'b1;
    wr(0);
    // Dropping activation lets the turn finish, then stops at the next grant
    @(posedge clk_sys);
    act <= 1'b0;
    wr(1);
    no_tx(40);
    // Full rotation from the administrator
    setup({8'h01, 8'h02, 8'h01, 8'h03, 8'h01, 8'h00, 8'h02});
    wr(0);
    chk("is_admin", 16'h0001, 16'(is_admin));
    chk("is_master", 16'h0001, 16'(is_master));
    wr(1);
    token(8'h02);
    chk("cur_master", 16'h0002, 16'(cur));
    token(8'h03);
    wr(0);
    wr(1);
    // Five sets with two invalid destinations skipped
    @(posedge clk_sys);
    dnode[23:16] <= 8'h00;
    dnode[39:32] <= 8'hf8;
    setup({8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00, 8'h05});
    wr(0);
    wr(1);
    wr(3);
    wr(0);
    // Timeout with halting action, then with ignore
    @(posedge clk_sys);
    tmo <= 8'h03;
    erract <= 8'h00;
    mute <= 1'b1;
    setup({8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h00, 8'h01});
    wr(0);
    token(8'h02);
    for (int i = 0; i < 60 && tmo_err !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("timeout_err", 16'h0001, 16'(tmo_err));
    no_tx(40);
    @(posedge clk_sys);
    erract <= ERR_IGNORE;
    setup({8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h00, 8'h01});
    wr(0);
    token(8'h02);
    wr(0);
    chk("timeout_err", 16'h0001, 16'(tmo_err));
    end_of_test();
  end
endmodule : idtw_core_tb
